// File: nfc_rx_cfg_pkg.sv
package nfc_rx_cfg_pkg;

    // =====================================================================
    // register map
    localparam logic [7:0] RX_CFG2_ADDR = 8'h0C;
    localparam logic [7:0] RX_CFG3_ADDR = 8'h0D;
    localparam logic [7:0] RX_CFG4_ADDR = 8'h0E;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // =====================================================================
    // reset values
    localparam logic [7:0] RX_CFG2_RESET = 8'h2C;
    localparam logic [7:0] RX_CFG3_RESET = 8'hD8;
    localparam logic [7:0] RX_CFG4_RESET = 8'h00;

    // =====================================================================
    // receiver_config_2 fields
    localparam int DEMOD_MODE_BIT = 7;
    localparam int AM_DEMOD_SEL_BIT = 6;
    localparam int AUTO_SQUELCH_BIT = 5;
    localparam int SQUELCH_RATIO_BIT = 4;
    localparam int AGC_ENABLE_BIT = 3;
    localparam int AGC_WINDOW_BIT = 2;
    localparam int AGC_ALG_BIT = 1;
    localparam int GAIN_CONTROL_RATIO_BIT = 0;

    // =====================================================================
    // receiver_config_3 fields
    localparam int AM_FIRST_GAIN_MSB = 7;
    localparam int AM_FIRST_GAIN_LSB = 5;
    localparam int PM_FIRST_GAIN_MSB = 4;
    localparam int PM_FIRST_GAIN_LSB = 2;
    localparam int LF_ENABLE_BIT = 1;
    localparam int LF_SPLIT_BIT = 0;
    localparam logic [2:0] FIRST_GAIN_BOOST_CODE = 3'h7;

    // =====================================================================
    // receiver_config_4 fields
    localparam int AM_LATER_GAIN_MSB = 7;
    localparam int AM_LATER_GAIN_LSB = 4;
    localparam int PM_LATER_GAIN_MSB = 3;
    localparam int PM_LATER_GAIN_LSB = 0;
    localparam logic [3:0] LATER_GAIN_MAX_CODE = 4'hA;
    localparam logic [3:0] LATER_WINDOW_LAST_CODE = 4'h4;

    // =====================================================================
    // timing
    localparam int CLK_FREQ_KHZ = 10000;
    localparam int SQUELCH_DELAY_NS = 18880;
    localparam int SQUELCH_DELAY_CYCLES_INT =
        (SQUELCH_DELAY_NS * CLK_FREQ_KHZ + 999999) / 1000000;
    localparam logic [7:0] SQUELCH_DELAY_CYCLES = SQUELCH_DELAY_CYCLES_INT[7:0];
    localparam logic [3:0] AGC_SHORT_WINDOW_PULSES = 4'h8;

endpackage

// File: nfc_receiver_config_regs.sv
// Contract
// - Demodulator select picks AM/PM at 0 and I/Q at 1; AM select picks peak detector at 0, mixer at 1.
// - With auto squelch on, squelch starts 18.88 us after transmit ends and holds until the mask timer reaches the squelch time.
// - The squelch ratio bit sets the trigger to 1x threshold at 0 and 6/3x at 1.
// - Gain control runs only when enabled, over the first eight pulses at window 0 or the whole reception at 1.
// - The algorithm bit picks preset at 0 and reset at 1.
// - The gain-control ratio bit triggers at 3x minimum level at 0 and 6x at 1.
// - Each first-stage code gives full gain at 0, 2.5 dB cuts per step for 1 to 6 and a boost at 7.
// - The low-frequency enable routes HF at 0 and LF at 1 to the receiver.
// - The split bit gives differential LF at 0, and at 1 first input to AM and second to PM.
// - Later-stage codes 1h to 4h widen only the digitizer window in 3 dB steps.
// - Later-stage codes 5h to Ah also cut gain in stages two and three in 3 dB steps.
// - Later-stage gain reaches the gain, squelch and strength logic only on the gain reset command.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module nfc_receiver_config_regs
    import nfc_rx_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [7:0] regRdData,
    input wire logic txEnd,
    input wire logic [7:0] maskTimer,
    input wire logic [7:0] squelchTime,
    input wire logic rxActive,
    input wire logic subcarrierPulse,
    input wire logic rxGainResetCmd,
    output logic demodIq,
    output logic amMixer,
    output logic squelchActive,
    output logic squelchRatioHigh,
    output logic agcRun,
    output logic agcAlgReset,
    output logic gainControlRatio6,
    output logic [2:0] amFirstReduceSteps,
    output logic amFirstBoost,
    output logic [2:0] pmFirstReduceSteps,
    output logic pmFirstBoost,
    output logic lowFreqInput,
    output logic lowFreqSplit,
    output logic rfInputFirstToAm,
    output logic rfInputSecondToPm,
    output logic [2:0] amWindowSteps,
    output logic [2:0] amStageSteps,
    output logic [2:0] pmWindowSteps,
    output logic [2:0] pmStageSteps
);

    // =====================================================================
    // decode helpers
    function automatic logic [2:0] first_reduce(input logic [2:0] code);
        first_reduce = (code == FIRST_GAIN_BOOST_CODE) ? 3'h0 : code;
    endfunction

    function automatic logic [3:0] later_clamp(input logic [3:0] code);
        later_clamp = (code > LATER_GAIN_MAX_CODE) ? LATER_GAIN_MAX_CODE : code;
    endfunction

    function automatic logic [2:0] later_window(input logic [3:0] code);
        logic [3:0] c;
        c = later_clamp(code);
        later_window = (c > LATER_WINDOW_LAST_CODE) ? LATER_WINDOW_LAST_CODE[2:0] : c[2:0];
    endfunction

    function automatic logic [2:0] later_stage(input logic [3:0] code);
        logic [3:0] c;
        logic [3:0] diff;
        c = later_clamp(code);
        diff = c - LATER_WINDOW_LAST_CODE;
        later_stage = (c > LATER_WINDOW_LAST_CODE) ? diff[2:0] : 3'h0;
    endfunction

    // =====================================================================
    // register file
    logic [7:0] cfg2_q;
    logic [7:0] cfg3_q;
    logic [7:0] cfg4_q;
    logic [7:0] laterShadow_q;
    logic [7:0] rdData_q;

    wire logic hitCfg2 = (regAddr == RX_CFG2_ADDR);
    wire logic hitCfg3 = (regAddr == RX_CFG3_ADDR);
    wire logic hitCfg4 = (regAddr == RX_CFG4_ADDR);
    wire logic [7:0] rdMux = hitCfg2 ? cfg2_q :
                             hitCfg3 ? cfg3_q :
                             hitCfg4 ? cfg4_q : UNMAPPED_READ;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg2_q <= RX_CFG2_RESET;
            cfg3_q <= RX_CFG3_RESET;
            cfg4_q <= RX_CFG4_RESET;
        end else if (regWrStrobe) begin
            if (hitCfg2) cfg2_q <= regWrData;
            if (hitCfg3) cfg3_q <= regWrData;
            if (hitCfg4) cfg4_q <= regWrData;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_q <= 8'h00;
        end else begin
            rdData_q <= regRdStrobe ? rdMux : 8'h00;
        end
    end

    // later-stage gain only moves on the reset-gain command
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            laterShadow_q <= RX_CFG4_RESET;
        end else if (rxGainResetCmd) begin
            laterShadow_q <= cfg4_q;
        end
    end

    // =====================================================================
    // squelch sequencer
    typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_HOLD} squelch_e;
    squelch_e sqState_q;
    squelch_e sqState_d;
    logic [7:0] sqCount_q;
    logic [7:0] sqCount_d;

    wire logic autoSquelch = cfg2_q[AUTO_SQUELCH_BIT];
    wire logic delayDone = (sqCount_q >= SQUELCH_DELAY_CYCLES - 8'h01);
    wire logic timerReached = (maskTimer >= squelchTime);

    always_comb begin
        sqState_d = sqState_q;
        sqCount_d = sqCount_q;
        case (sqState_q)
            SQ_IDLE: begin
                sqCount_d = 8'h00;
                if (autoSquelch && txEnd) begin
                    sqState_d = SQ_WAIT;
                end
            end
            SQ_WAIT: begin
                sqCount_d = sqCount_q + 8'h01;
                if (delayDone) begin
                    sqState_d = SQ_HOLD;
                end
            end
            SQ_HOLD: begin
                sqCount_d = 8'h00;
                if (timerReached) begin
                    sqState_d = SQ_IDLE;
                end
            end
            default: begin
                sqState_d = SQ_IDLE;
                sqCount_d = 8'h00;
            end
        endcase
        if (!autoSquelch) begin
            sqState_d = SQ_IDLE;
            sqCount_d = 8'h00;
        end else if (txEnd && sqState_q != SQ_IDLE) begin
            sqState_d = SQ_WAIT;
            sqCount_d = 8'h00;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sqState_q <= SQ_IDLE;
            sqCount_q <= 8'h00;
        end else begin
            sqState_q <= sqState_d;
            sqCount_q <= sqCount_d;
        end
    end

    // =====================================================================
    // gain-control window
    logic [3:0] pulseCount_q;
    wire logic agcEnable = cfg2_q[AGC_ENABLE_BIT];
    wire logic agcWholeRx = cfg2_q[AGC_WINDOW_BIT];
    wire logic shortWindowOpen = (pulseCount_q < AGC_SHORT_WINDOW_PULSES);
    wire logic agcRunD = agcEnable && rxActive && (agcWholeRx || shortWindowOpen);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pulseCount_q <= 4'h0;
        end else if (!rxActive) begin
            pulseCount_q <= 4'h0;
        end else if (subcarrierPulse && shortWindowOpen) begin
            pulseCount_q <= pulseCount_q + 4'h1;
        end
    end

    // =====================================================================
    // decoded settings
    wire logic [2:0] amFirstCode = cfg3_q[AM_FIRST_GAIN_MSB:AM_FIRST_GAIN_LSB];
    wire logic [2:0] pmFirstCode = cfg3_q[PM_FIRST_GAIN_MSB:PM_FIRST_GAIN_LSB];
    wire logic [3:0] amLaterCode = laterShadow_q[AM_LATER_GAIN_MSB:AM_LATER_GAIN_LSB];
    wire logic [3:0] pmLaterCode = laterShadow_q[PM_LATER_GAIN_MSB:PM_LATER_GAIN_LSB];
    wire logic lfEnable = cfg3_q[LF_ENABLE_BIT];
    wire logic lfSplit = cfg3_q[LF_SPLIT_BIT];

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            demodIq <= RX_CFG2_RESET[DEMOD_MODE_BIT];
            amMixer <= RX_CFG2_RESET[AM_DEMOD_SEL_BIT];
            squelchRatioHigh <= RX_CFG2_RESET[SQUELCH_RATIO_BIT];
            agcAlgReset <= RX_CFG2_RESET[AGC_ALG_BIT];
            gainControlRatio6 <= RX_CFG2_RESET[GAIN_CONTROL_RATIO_BIT];
            squelchActive <= 1'b0;
            agcRun <= 1'b0;
        end else begin
            demodIq <= cfg2_q[DEMOD_MODE_BIT];
            amMixer <= cfg2_q[AM_DEMOD_SEL_BIT];
            squelchRatioHigh <= cfg2_q[SQUELCH_RATIO_BIT];
            agcAlgReset <= cfg2_q[AGC_ALG_BIT];
            gainControlRatio6 <= cfg2_q[GAIN_CONTROL_RATIO_BIT];
            squelchActive <= (sqState_d == SQ_HOLD);
            agcRun <= agcRunD;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            amFirstReduceSteps <= 3'h6;
            amFirstBoost <= 1'b0;
            pmFirstReduceSteps <= 3'h6;
            pmFirstBoost <= 1'b0;
            lowFreqInput <= 1'b0;
            lowFreqSplit <= 1'b0;
            rfInputFirstToAm <= 1'b0;
            rfInputSecondToPm <= 1'b0;
        end else begin
            amFirstReduceSteps <= first_reduce(amFirstCode);
            amFirstBoost <= (amFirstCode == FIRST_GAIN_BOOST_CODE);
            pmFirstReduceSteps <= first_reduce(pmFirstCode);
            pmFirstBoost <= (pmFirstCode == FIRST_GAIN_BOOST_CODE);
            lowFreqInput <= lfEnable;
            lowFreqSplit <= lfEnable && lfSplit;
            rfInputFirstToAm <= lfEnable && lfSplit;
            rfInputSecondToPm <= lfEnable && lfSplit;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            amWindowSteps <= 3'h0;
            amStageSteps <= 3'h0;
            pmWindowSteps <= 3'h0;
            pmStageSteps <= 3'h0;
        end else begin
            amWindowSteps <= later_window(amLaterCode);
            amStageSteps <= later_stage(amLaterCode);
            pmWindowSteps <= later_window(pmLaterCode);
            pmStageSteps <= later_stage(pmLaterCode);
        end
    end

    assign regRdData = rdData_q;

endmodule

`default_nettype wire

// File: nfc_receiver_config_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module nfc_rx_cfg_checker
    import nfc_rx_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    input wire logic [7:0] regRdData,
    input wire logic txEnd,
    input wire logic rxActive,
    input wire logic rxGainResetCmd,
    input wire logic demodIq,
    input wire logic amMixer,
    input wire logic squelchActive,
    input wire logic squelchRatioHigh,
    input wire logic agcRun,
    input wire logic amFirstBoost,
    input wire logic [2:0] amWindowSteps,
    input wire logic [2:0] amStageSteps
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [7:0] wdA_q, wdB_q;
    // write data two cycles back, matched to output lag
    always_ff @(posedge mclk) begin
        wdA_q <= regWrData;
        wdB_q <= wdA_q;
    end
    sequence s_wr(logic [7:0] a);
        regWrStrobe && regAddr == a;
    endsequence
    property p_demod; s_wr(RX_CFG2_ADDR) |-> ##2 demodIq == wdB_q[7] && amMixer == wdB_q[6]; endproperty
    a_demod: assert property (p_demod) else $error("demod select wrong");
    property p_ratio; s_wr(RX_CFG2_ADDR) |-> ##2 squelchRatioHigh == wdB_q[4]; endproperty
    a_ratio: assert property (p_ratio) else $error("squelch ratio wrong");
    property p_boost; s_wr(RX_CFG3_ADDR) |-> ##2 amFirstBoost == (wdB_q[7:5] == 3'h7); endproperty
    a_boost: assert property (p_boost) else $error("first stage boost wrong");
    property p_sq_start; $rose(squelchActive) |-> $past(txEnd, 190); endproperty
    a_sq_start: assert property (p_sq_start) else $error("squelch start timing wrong");
    property p_agc; !rxActive |=> !agcRun; endproperty
    a_agc: assert property (p_agc) else $error("gain control outside reception");
    property p_hold;
        !rxGainResetCmd && !$past(rxGainResetCmd) |=> $stable(amWindowSteps) && $stable(amStageSteps);
    endproperty
    a_hold: assert property (p_hold) else $error("later gain moved without command");
    property p_shape; amWindowSteps <= 3'h4 && (amStageSteps == 3'h0 || amWindowSteps == 3'h4); endproperty
    a_shape: assert property (p_shape) else $error("later gain split wrong");
    property p_rd_idle;
        (!regRdStrobe || regAddr < RX_CFG2_ADDR || regAddr > RX_CFG4_ADDR) |=> regRdData == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
endmodule
bind nfc_receiver_config_regs nfc_rx_cfg_checker u_checker (.mclk, .sys_rst, .regAddr,
    .regWrData, .regWrStrobe, .regRdStrobe, .regRdData, .txEnd, .rxActive, .rxGainResetCmd,
    .demodIq, .amMixer, .squelchActive, .squelchRatioHigh, .agcRun, .amFirstBoost,
    .amWindowSteps, .amStageSteps);
`default_nettype wire

// File: nfc_rx_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module nfc_rx_host_model (
    input wire logic mclk,
    input wire logic [7:0] regRdData,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrStrobe,
    output logic regRdStrobe,
    output logic rxGainResetCmd
);
    initial {regAddr, regWrData, regWrStrobe, regRdStrobe, rxGainResetCmd} = '0;
    // one strobe cycle, then the cycle where read data stand
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= w;
        regRdStrobe <= !w;
        @(posedge mclk);
        regWrStrobe <= 1'b0;
        regRdStrobe <= 1'b0;
        @(posedge mclk);
        q = regRdData;
    endtask
    task automatic cmd;
        @(posedge mclk);
        rxGainResetCmd <= 1'b1;
        @(posedge mclk);
        rxGainResetCmd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: nfc_receiver_config_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module nfc_receiver_config_regs_bench
    import nfc_rx_cfg_pkg::*;
;
    logic mclk = 1'b0, sys_rst = 1'b1, txEnd = 1'b0, rxActive = 1'b0, subcarrierPulse = 1'b0;
    logic regWrStrobe, regRdStrobe, rxGainResetCmd, demodIq, amMixer, squelchActive, agcRun;
    logic squelchRatioHigh, agcAlgReset, gainControlRatio6, amFirstBoost, lowFreqInput;
    logic lowFreqSplit, pmFirstBoost, rfInputFirstToAm, rfInputSecondToPm;
    logic [2:0] pmFirstReduceSteps, pmWindowSteps, pmStageSteps;
    logic [7:0] regAddr, regWrData, regRdData, q, d, e, p, maskTimer = 8'h00;
    logic [7:0] squelchTime = 8'h06;
    logic [2:0] amFirstReduceSteps, amWindowSteps, amStageSteps;
    int failures = 0, samplesChecked = 0, seed = 82832;
    wire [7:0] cfg2Out = {3'h0, demodIq, amMixer, squelchRatioHigh, agcAlgReset, gainControlRatio6};
    wire [7:0] cfg3Out = {2'h0, amFirstBoost, amFirstReduceSteps, lowFreqInput, lowFreqSplit};
    wire [7:0] laterOut = {1'b0, amWindowSteps, 1'b0, amStageSteps};
    wire [7:0] pmLaterOut = {1'b0, pmWindowSteps, 1'b0, pmStageSteps};
    wire [7:0] pmOut = {pmFirstBoost, pmFirstReduceSteps, rfInputFirstToAm, rfInputSecondToPm, 2'h0};
    nfc_receiver_config_regs u_dut (.mclk, .sys_rst, .regAddr, .regWrData, .regWrStrobe,
        .regRdStrobe, .regRdData, .txEnd, .maskTimer, .squelchTime, .rxActive,
        .subcarrierPulse, .rxGainResetCmd, .demodIq, .amMixer, .squelchActive,
        .squelchRatioHigh, .agcRun, .agcAlgReset, .gainControlRatio6, .amFirstReduceSteps,
        .amFirstBoost, .pmFirstReduceSteps, .pmFirstBoost, .lowFreqInput, .lowFreqSplit,
        .rfInputFirstToAm, .rfInputSecondToPm, .amWindowSteps, .amStageSteps,
        .pmWindowSteps, .pmStageSteps);
    nfc_rx_host_model u_host (.mclk, .regRdData, .regAddr, .regWrData, .regWrStrobe,
        .regRdStrobe, .rxGainResetCmd);
    initial forever #50 mclk = ~mclk;
    function automatic logic [7:0] cfg3_exp(input logic [7:0] v);
        return {2'h0, v[7:5] == 3'h7, (v[7:5] == 3'h7) ? 3'h0 : v[7:5], v[1], v[1] & v[0]};
    endfunction
    function automatic logic [7:0] later_exp(input logic [3:0] c);
        return (c > 4'h4) ? {4'h4, c - 4'h4} : {c, 4'h0};
    endfunction
    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        samplesChecked++;
        if (s !== x) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        failures++;
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            u_host.xfer(1'b0, 8'h0C + a[7:0], 8'h00, q);
            chk(q, (a == 0) ? 8'h2C : (a == 1) ? 8'hD8 : 8'h00);
        end
        $display("test defaults done");
        p = 8'h00;
        for (int i = 0; i < 24; i++) begin
            d = 8'($random(seed));
            if (i < 8) d[7:5] = i[2:0];
            d[6] = d[6] | d[7];
            e = {4'(i % 11), 4'($unsigned($random(seed)) % 11)};
            u_host.xfer(1'b1, RX_CFG2_ADDR, d, q);
            u_host.xfer(1'b1, RX_CFG3_ADDR, d, q);
            u_host.xfer(1'b1, RX_CFG4_ADDR, e, q);
            idle(1);
            chk(cfg2Out, {3'h0, d[7], d[6], d[4], d[1], d[0]});
            chk(cfg3Out, cfg3_exp(d));
            chk(laterOut, later_exp(p[7:4]));
            chk(pmLaterOut, later_exp(p[3:0]));
            chk(pmOut, {d[4:2] == 3'h7, (d[4:2] == 3'h7) ? 3'h0 : d[4:2], d[1] & d[0], d[1] & d[0], 2'h0});
            u_host.xfer(1'b0, RX_CFG4_ADDR, 8'h00, q);
            chk(q, e);
            u_host.cmd;
            idle(2);
            chk(laterOut, later_exp(e[7:4]));
            chk(pmLaterOut, later_exp(e[3:0]));
            p = e;
        end
        $display("test fields done");
        for (int b = 1; b >= 0; b--) begin
            u_host.xfer(1'b1, RX_CFG2_ADDR, {2'h0, b[0], 5'h00}, q);
            maskTimer <= 8'h00;
            @(posedge mclk) txEnd <= 1'b1;
            @(posedge mclk) txEnd <= 1'b0;
            idle(189);
            chk({7'h0, squelchActive}, 8'h00);
            idle(1);
            chk({7'h0, squelchActive}, {7'h0, b[0]});
            @(posedge mclk) maskTimer <= squelchTime;
            idle(3);
            chk({7'h0, squelchActive}, 8'h00);
        end
        $display("test squelch done");
        u_host.xfer(1'b1, RX_CFG2_ADDR, 8'h08, q);
        rxActive <= 1'b1;
        idle(1);
        for (int n = 0; n <= 8; n++) begin
            idle(2);
            chk({7'h0, agcRun}, {7'h0, n < 8});
            @(posedge mclk) subcarrierPulse <= 1'b1;
            @(posedge mclk) subcarrierPulse <= 1'b0;
        end
        for (int k = 0; k < 2; k++) begin
            u_host.xfer(1'b1, RX_CFG2_ADDR, k ? 8'h04 : 8'h0C, q);
            idle(1);
            chk({7'h0, agcRun}, {7'h0, !k});
        end
        $display("test gain control done");
        wrap_up;
    end
endmodule
`default_nettype wire
